// *** pkg/bmfd_pkg.sv ***
// Constants, types and helpers for the fragment decoder.
package bmfd_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 21;
  localparam logic [4:0] BITS_PER_WORD = 5'h15;
  localparam int NIB_W = 4;
  localparam int CHK_LSB = 0;
  localparam int CHK_W = 10;
  localparam int CONT_BIT = 10;
  localparam int FRAG_LSB = 11;
  localparam int NUM_LSB = 13;
  localparam int NUM_W = 6;
  localparam int RETR_BIT = 19;
  localparam int MAIL_BIT = 20;
  localparam int BLK_LSB = 0;
  localparam int DIR_BIT = 4;
  localparam int HDR_BIT = 5;
  localparam int SIG_LSB = 11;
  localparam logic [1:0] FRAG_INIT = 2'h3;
  localparam logic [1:0] FRAG_WRAP = 2'h2;
  localparam logic [3:0] BLK_BINARY = 4'h1;

  // ----------------------------------------------------------------
  // Register map and status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_INFO = 8'h0c;
  localparam logic [7:0] OFS_SIG = 8'h10;
  localparam logic CTRL_RST = 1'b1;
  localparam int ST_W = 5;
  localparam int ST_DONE = 0;
  localparam int ST_SIGERR = 1;
  localparam int ST_SEQERR = 2;
  localparam int ST_DIRERR = 3;
  localparam int ST_PAIR = 4;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;

  // Decoder sequencing states.
  typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_DONE} bmfd_state_t;

  // Fragment number expected after the given one.
  function automatic logic [1:0] bmfd_frag_next(input logic [1:0] f);
    bmfd_frag_next = (f == FRAG_INIT || f == FRAG_WRAP) ? 2'h0 : f + 2'h1;
  endfunction : bmfd_frag_next

endpackage : bmfd_pkg

// *** hw/bmfd_fill_finder.sv ***
// Locates the end of valid data in a fragment's last word.
`timescale 1ns/1ps
module bmfd_fill_finder (
  input wire logic [bmfd_pkg::WORD_W-1:0] word,
  output logic [4:0] count
);

  // ----------------------------------------------------------------
  // Fill search
  // ----------------------------------------------------------------
  // Returns one past the highest bit that differs from the top bit.
  function automatic logic [4:0] last_valid(input logic [bmfd_pkg::WORD_W-1:0] w);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < bmfd_pkg::WORD_W - 1; i++) begin
      if (w[i] != w[bmfd_pkg::WORD_W-1]) begin
        c = 5'(i + 1);
      end
    end
    last_valid = c;
  endfunction : last_valid

  // A word of uniform polarity holds no data at all.
  always_comb begin
    count = last_valid(word);
  end

endmodule : bmfd_fill_finder

// *** hw/bmfd_decoder.sv ***
// Hex/binary message fragment decoder with APB registers.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module bmfd_decoder #(
  parameter int ADDR_W = 8
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WORD_VALID,
  input wire logic [bmfd_pkg::WORD_W-1:0] WORD_DATA,
  input wire logic WORD_LAST,
  output logic WORD_READY,
  output logic NIB_VALID,
  output logic [bmfd_pkg::NIB_W-1:0] NIB_DATA,
  output logic MSG_DONE,
  output logic [bmfd_pkg::NUM_W-1:0] MSG_NUM,
  output logic MSG_HDR,
  output logic DISP_RTL,
  output logic SIG_ERR,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 8.");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bmfd_pkg::bmfd_state_t state; // Sequencer state.
  logic [bmfd_pkg::WORD_W-1:0] shreg; // Word being shifted out.
  logic [4:0] bit_pos; // Bits consumed of the current word.
  logic [4:0] bit_lim; // Valid bits of the current word.
  logic [4:0] fill_cnt; // Valid bits if this is the last word.
  logic last_word; // Current word closes the fragment.
  logic [1:0] word_idx; // Word position within the fragment.
  logic first_frag; // Current fragment opened the message.
  logic msg_active; // A message is in progress.
  logic cont; // Continued flag of this fragment.
  logic [1:0] frag_num; // Fragment number of this fragment.
  logic [bmfd_pkg::CHK_W-1:0] chk_rx; // Received checksum field.
  logic retr; // Retrieval flag.
  logic mail; // Mail drop flag.
  logic [3:0] blk_len; // Blocking length field.
  logic dir; // Raw display direction.
  logic [7:0] sig_rx; // Received signature.
  logic [1:0] nib_cnt; // Bits held in the nibble assembler.
  logic [2:0] nib_acc; // Lower bits of the nibble in progress.
  logic half; // A low nibble waits for its partner.
  logic [3:0] low_nib; // The waiting low nibble.
  logic [7:0] sum; // Running byte sum.
  logic [7:0] final_sum; // Sum with any odd nibble folded in.
  logic prev_hdr; // Previous message was a header.
  logic [bmfd_pkg::NUM_W-1:0] prev_num; // Previous message number.
  logic ctrl_en; // Decoder enable.
  logic [bmfd_pkg::ST_W-1:0] status; // Sticky event bits.
  logic [bmfd_pkg::ST_W-1:0] mask; // Interrupt mask.
  logic [bmfd_pkg::ST_W-1:0] stat_cap; // Status bits shown to a read.
  logic [bmfd_pkg::ST_W-1:0] events; // Events of this cycle.
  logic [7:0] addr; // Byte address, zero extended.
  logic take, hdr_take, ext_take, data_take; // Word acceptance classes.
  logic bit_step, word_end, frag_end, frag_cont, msg_start;
  logic seq_bad, dir_bad, pair_hit, sig_bad;
  logic acc, setup, mapped; // Bus phase decode.
  logic [31:0] next_rdata; // Read data selected in setup.

  // ----------------------------------------------------------------
  // Word acceptance and event decode
  // ----------------------------------------------------------------
  // Words are taken only while idle and enabled.
  assign WORD_READY = ctrl_en && (state == bmfd_pkg::S_IDLE);
  assign take = WORD_VALID && WORD_READY;
  assign hdr_take = take && (word_idx == 2'h0);
  assign ext_take = take && (word_idx == 2'h1) && first_frag;
  assign data_take = take && !hdr_take && !ext_take;
  assign bit_step = (state == bmfd_pkg::S_SHIFT) && (bit_pos != bit_lim);
  assign word_end = (state == bmfd_pkg::S_SHIFT) && (bit_pos == bit_lim);
  assign frag_end = (word_end && last_word) || (take && WORD_LAST && !data_take);
  assign frag_cont = hdr_take ? WORD_DATA[bmfd_pkg::CONT_BIT] : cont;
  assign msg_start = hdr_take &&
    (WORD_DATA[bmfd_pkg::FRAG_LSB +: 2] == bmfd_pkg::FRAG_INIT);

  // A later fragment must carry the successor number of an open message.
  assign seq_bad = hdr_take && !msg_start &&
    (!msg_active || WORD_DATA[bmfd_pkg::FRAG_LSB +: 2] != bmfd_pkg::bmfd_frag_next(frag_num));

  // Right-to-left is refused for binary blocking.
  assign dir_bad = ext_take && WORD_DATA[bmfd_pkg::DIR_BIT] &&
    (WORD_DATA[bmfd_pkg::BLK_LSB +: 4] == bmfd_pkg::BLK_BINARY);

  // An odd trailing nibble counts as a byte with a zero high half.
  assign final_sum = half ? sum + {4'h0, low_nib} : sum;
  assign sig_bad = (state == bmfd_pkg::S_DONE) && ((~final_sum) != sig_rx);
  assign pair_hit = (state == bmfd_pkg::S_DONE) && !MSG_HDR && prev_hdr &&
    (prev_num == MSG_NUM);

  // The fill finder looks at the incoming word.
  bmfd_fill_finder u_fill (
    .word (WORD_DATA),
    .count (fill_cnt)
  );

  // ----------------------------------------------------------------
  // Sequencer and bit shifter
  // ----------------------------------------------------------------
  // Data words are consumed one bit per clock, low bit first.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= bmfd_pkg::S_IDLE;
      shreg <= '0;
      bit_pos <= 5'h00;
      bit_lim <= 5'h00;
      last_word <= 1'b0;
    end else begin
      case (state)
        bmfd_pkg::S_IDLE: begin
          if (data_take) begin
            // Only the closing word is trimmed of its fill.
            state <= bmfd_pkg::S_SHIFT;
            shreg <= WORD_DATA;
            bit_pos <= 5'h00;
            bit_lim <= WORD_LAST ? fill_cnt : bmfd_pkg::BITS_PER_WORD;
            last_word <= WORD_LAST;
          end else if (frag_end && !frag_cont) begin
            state <= bmfd_pkg::S_DONE;
          end
        end
        bmfd_pkg::S_SHIFT: begin
          if (bit_step) begin
            shreg <= shreg >> 1;
            bit_pos <= bit_pos + 5'h01;
          end else if (frag_end && !frag_cont) begin
            state <= bmfd_pkg::S_DONE;
          end else begin
            state <= bmfd_pkg::S_IDLE;
          end
        end
        bmfd_pkg::S_DONE: begin
          state <= bmfd_pkg::S_IDLE;
        end
        default: begin
          state <= bmfd_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fragment first word
  // ----------------------------------------------------------------
  // Every fragment opens with checksum, flags and message number.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      word_idx <= 2'h0;
      first_frag <= 1'b0;
      msg_active <= 1'b0;
      cont <= 1'b0;
      frag_num <= bmfd_pkg::FRAG_INIT;
      chk_rx <= '0;
      MSG_NUM <= '0;
      retr <= 1'b0;
      mail <= 1'b0;
    end else begin
      if (hdr_take) begin
        // Checksum is kept for software; it is not recomputed here.
        cont <= WORD_DATA[bmfd_pkg::CONT_BIT];
        frag_num <= WORD_DATA[bmfd_pkg::FRAG_LSB +: 2];
        chk_rx <= WORD_DATA[bmfd_pkg::CHK_LSB +: bmfd_pkg::CHK_W];
        MSG_NUM <= WORD_DATA[bmfd_pkg::NUM_LSB +: bmfd_pkg::NUM_W];
        retr <= WORD_DATA[bmfd_pkg::RETR_BIT];
        mail <= WORD_DATA[bmfd_pkg::MAIL_BIT];
        first_frag <= msg_start;
        msg_active <= msg_start || msg_active;
      end
      if (frag_end) begin
        word_idx <= 2'h0;
        if (!frag_cont) begin
          msg_active <= 1'b0;
        end
      end else if (take && word_idx != 2'h2) begin
        word_idx <= word_idx + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // First fragment extension word
  // ----------------------------------------------------------------
  // The reserved bits between header flag and signature are skipped.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      blk_len <= 4'h0;
      dir <= 1'b0;
      MSG_HDR <= 1'b0;
      sig_rx <= 8'h00;
    end else if (ext_take) begin
      blk_len <= WORD_DATA[bmfd_pkg::BLK_LSB +: 4];
      dir <= WORD_DATA[bmfd_pkg::DIR_BIT];
      MSG_HDR <= WORD_DATA[bmfd_pkg::HDR_BIT];
      sig_rx <= WORD_DATA[bmfd_pkg::SIG_LSB +: 8];
    end
  end

  // Right-to-left shows only for character blocking.
  assign DISP_RTL = dir && (blk_len != bmfd_pkg::BLK_BINARY);

  // ----------------------------------------------------------------
  // Nibble assembly and signature sum
  // ----------------------------------------------------------------
  // Four bits make a nibble; two nibbles make a byte of the sum.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      nib_cnt <= 2'h0;
      nib_acc <= 3'h0;
      half <= 1'b0;
      low_nib <= 4'h0;
      sum <= 8'h00;
      NIB_VALID <= 1'b0;
      NIB_DATA <= 4'h0;
    end else begin
      NIB_VALID <= 1'b0;
      if (msg_start) begin
        half <= 1'b0;
        sum <= 8'h00;
      end
      if (msg_start || frag_end) begin
        // Fragments end on a character boundary, so no bits are lost.
        nib_cnt <= 2'h0;
      end else if (bit_step) begin
        nib_cnt <= nib_cnt + 2'h1;
        if (nib_cnt == 2'h3) begin
          NIB_VALID <= 1'b1;
          NIB_DATA <= {shreg[0], nib_acc};
          half <= !half;
          if (half) begin
            sum <= sum + {shreg[0], nib_acc, low_nib};
          end else begin
            low_nib <= {shreg[0], nib_acc};
          end
        end else begin
          nib_acc[nib_cnt] <= shreg[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Message verdict and header pairing
  // ----------------------------------------------------------------
  // The error stays up until the next message opens.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      SIG_ERR <= 1'b0;
      MSG_DONE <= 1'b0;
      prev_hdr <= 1'b0;
      prev_num <= '0;
    end else begin
      MSG_DONE <= (state == bmfd_pkg::S_DONE);
      if (sig_bad) begin
        SIG_ERR <= 1'b1;
      end else if (msg_start) begin
        SIG_ERR <= 1'b0;
      end
      // Only the message right before may be a header for this one.
      if (state == bmfd_pkg::S_DONE) begin
        prev_hdr <= MSG_HDR;
        prev_num <= MSG_NUM;
      end else if (msg_start && msg_active) begin
        prev_hdr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave and interrupt
  // ----------------------------------------------------------------
  assign addr = 8'(PADDR);
  assign acc = PSEL && PENABLE;
  assign setup = PSEL && !PENABLE;
  assign mapped = (addr == bmfd_pkg::OFS_CTRL) || (addr == bmfd_pkg::OFS_STAT) ||
    (addr == bmfd_pkg::OFS_MASK) || (addr == bmfd_pkg::OFS_INFO) ||
    (addr == bmfd_pkg::OFS_SIG);
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !mapped;

  // Events that set the sticky status bits.
  always_comb begin
    events = '0;
    events[bmfd_pkg::ST_DONE] = (state == bmfd_pkg::S_DONE);
    events[bmfd_pkg::ST_SIGERR] = sig_bad;
    events[bmfd_pkg::ST_SEQERR] = seq_bad;
    events[bmfd_pkg::ST_DIRERR] = dir_bad;
    events[bmfd_pkg::ST_PAIR] = pair_hit;
  end

  // Read data selection; unmapped words read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (addr)
      bmfd_pkg::OFS_CTRL: next_rdata[0] = ctrl_en;
      bmfd_pkg::OFS_STAT: next_rdata[bmfd_pkg::ST_W-1:0] = status;
      bmfd_pkg::OFS_MASK: next_rdata[bmfd_pkg::ST_W-1:0] = mask;
      bmfd_pkg::OFS_INFO: next_rdata[21:0] = {chk_rx, blk_len, DISP_RTL, MSG_HDR,
        mail, retr, cont, frag_num, first_frag};
      bmfd_pkg::OFS_SIG: next_rdata[23:0] = {final_sum, ~final_sum, sig_rx};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
      stat_cap <= '0;
    end else if (setup && !PWRITE) begin
      PRDATA <= next_rdata;
      stat_cap <= (addr == bmfd_pkg::OFS_STAT) ? status : '0;
    end
  end

  // Writable control and mask registers.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_en <= bmfd_pkg::CTRL_RST;
      mask <= bmfd_pkg::MASK_RST;
    end else if (acc && PWRITE) begin
      if (addr == bmfd_pkg::OFS_CTRL) begin
        ctrl_en <= PWDATA[0];
      end
      if (addr == bmfd_pkg::OFS_MASK) begin
        mask <= PWDATA[bmfd_pkg::ST_W-1:0];
      end
    end
  end

  // A read clears only what it showed; new events win over the clear.
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      status <= '0;
    end else if (acc && !PWRITE && addr == bmfd_pkg::OFS_STAT) begin
      status <= (status & ~stat_cap) | events;
    end else begin
      status <= status | events;
    end
  end

  assign IRQ = |(status & mask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  a_sig_err_hold: assert property (SIG_ERR && !msg_start |=> SIG_ERR)
    else $error("Signature error dropped before next message.");
  a_sig_compare: assert property (sig_bad |=> SIG_ERR && status[bmfd_pkg::ST_SIGERR])
    else $error("Signature mismatch not flagged.");
  a_sig_good: assert property ((state == bmfd_pkg::S_DONE) && !SIG_ERR &&
    ((~final_sum) == sig_rx) |=> !SIG_ERR)
    else $error("Signature error raised on a match.");
  a_frag_seq: assert property (seq_bad |=> status[bmfd_pkg::ST_SEQERR])
    else $error("Fragment sequence error not flagged.");
  a_word_bits: assert property (data_take && !WORD_LAST |-> ##22 word_end)
    else $error("Full data word not consumed in 21 bits.");
  a_fill_word: assert property (data_take && WORD_LAST && fill_cnt == 5'h00 |=>
    word_end)
    else $error("Uniform fill word carried data.");
  a_nib_emit: assert property (bit_step && nib_cnt == 2'h3 && !frag_end |=>
    NIB_VALID ##1 !NIB_VALID)
    else $error("Nibble not emitted after four bits.");
  a_pair_hdr: assert property (pair_hit |=> status[bmfd_pkg::ST_PAIR] && prev_num == MSG_NUM &&
    !prev_hdr)
    else $error("Header pairing not reported.");
  a_dir_binary: assert property (dir_bad |=> !DISP_RTL && status[bmfd_pkg::ST_DIRERR])
    else $error("Right-to-left accepted for binary.");
  a_num_latch: assert property (hdr_take |=> MSG_NUM ==
    $past(WORD_DATA[bmfd_pkg::NUM_LSB +: bmfd_pkg::NUM_W]))
    else $error("Message number not latched.");
  a_cont_frag: assert property (frag_end && frag_cont |=> state == bmfd_pkg::S_IDLE &&
    word_idx == 2'h0)
    else $error("Continued fragment closed the message.");

  c_msg_done: cover property ((state == bmfd_pkg::S_DONE) && !sig_bad);
  c_sig_err: cover property (sig_bad);
  c_pair: cover property (pair_hit);
  c_multi: cover property (hdr_take && !msg_start && !seq_bad);

endmodule : bmfd_decoder

// *** tb/bmfd_word_src.sv ***
// Channel model that packs message fragments into words for the decoder.
`timescale 1ns/1ps
module bmfd_word_src (
  input wire logic clk,
  input wire logic ready,
  output logic valid = 1'h0,
  output logic [20:0] data = 21'h0,
  output logic last = 1'h0
);
  // Holds a word until taken, then releases it with inverted data.
  task automatic send(input logic [20:0] w, input logic l);
    valid <= 1'h1;
    data <= w;
    last <= l;
    do @(posedge clk); while (ready !== 1'h1);
    valid <= 1'h0;
    data <= ~w;
    last <= 1'h0;
    repeat (1 + $urandom_range(2)) @(posedge clk);
  endtask : send

  // Sends one fragment: first word, extension word when initial, data words.
  task automatic frag(input logic [1:0] f, input logic c, input logic [5:0] n,
                      input logic [20:0] ext, input logic [3:0] nb[$]);
    logic b[$];
    logic [20:0] w[$];
    logic [20:0] x;
    logic [11:0] s;
    logic fb;
    s = 12'h0;
    x = 21'h0;
    foreach (nb[i]) for (int k = 0; k < 4; k++) b.push_back(nb[i][k]);
    fb = ~b[$];
    // Data that ends on a word's last bit always gets a whole word of fill.
    if (b.size() % 21 == 0) repeat (21) b.push_back(fb);
    while (b.size() % 21 != 0) b.push_back(fb);
    foreach (b[i]) begin
      x[i % 21] = b[i];
      if (i % 21 == 20) w.push_back(x);
    end
    if (f == bmfd_pkg::FRAG_INIT) w.push_front(ext);
    w.push_front({2'h0, n, f, c, 10'h0});
    foreach (w[i]) s += w[i][7:0] + w[i][15:8] + w[i][20:16];
    w[0][9:0] = ~s[9:0];
    foreach (w[i]) send(w[i], i == w.size() - 1);
  endtask : frag
endmodule : bmfd_word_src

// *** tb/bmfd_decoder_tb.sv ***
// Self-checking bench for the message fragment decoder.
`timescale 1ns/1ps
module bmfd_decoder_tb;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, wvalid, wlast, wready, nvalid, mdone, hdr, rtl, serr, irq;
  logic [20:0] wdata;
  logic [3:0] ndata;
  logic [5:0] mnum;
  logic [3:0] exp_nib[$];
  logic [8:0] exp_done[$];
  logic [7:0] last_sig;
  int num_errors = 0;
  int samples_checked = 0;

  always #20 ref_clk = ~ref_clk;

  bmfd_decoder bmfd_decoder_i (.REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WORD_VALID(wvalid), .WORD_DATA(wdata),
    .WORD_LAST(wlast), .WORD_READY(wready), .NIB_VALID(nvalid), .NIB_DATA(ndata),
    .MSG_DONE(mdone), .MSG_NUM(mnum), .MSG_HDR(hdr), .DISP_RTL(rtl), .SIG_ERR(serr),
    .IRQ(irq));

  bmfd_word_src bmfd_word_src_i (.clk(ref_clk), .ready(wready), .valid(wvalid),
    .data(wdata), .last(wlast));

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; checks the error flag and, for reads, the data.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic ee);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    chk(pslverr, ee);
    if (!w) chk(prdata, ex);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask : apb

  // Sends a message split into fragments and notes what must come out.
  task automatic msg(input int cnt[$], input logic [5:0] n, input logic [3:0] blk,
                     input logic d, input logic h, input logic bad, input logic z);
    logic [3:0] all[$];
    logic [7:0] sum;
    logic [1:0] f;
    int k;
    sum = 8'h0;
    f = bmfd_pkg::FRAG_INIT;
    k = 0;
    foreach (cnt[j]) repeat (cnt[j]) all.push_back(4'($urandom));
    if (z) all[$] = 4'h0;
    foreach (all[i]) sum += (i % 2) ? {all[i], 4'h0} : {4'h0, all[i]};
    sum = ~sum ^ {7'h0, bad};
    last_sig = sum;
    exp_nib = {exp_nib, all};
    exp_done.push_back({h, d && blk != bmfd_pkg::BLK_BINARY, bad, n});
    foreach (cnt[j]) begin
      bmfd_word_src_i.frag(f, j != cnt.size() - 1, n, {2'h0, sum, 5'h0, h, d, blk},
                           all[k:k + cnt[j] - 1]);
      k += cnt[j];
      f = (f == 2'h2 || f == 2'h3) ? 2'h0 : f + 2'h1;
    end
    for (int i = 0; i < 400 && exp_done.size() != 0; i++) @(posedge ref_clk);
    chk(exp_done.size(), 0);
    chk(exp_nib.size(), 0);
  endtask : msg

  // Watches the outputs and compares them against the oldest notes.
  always @(posedge ref_clk) begin
    if (nvalid === 1'h1) chk(ndata, exp_nib.size() ? exp_nib.pop_front() : 4'hx);
    if (mdone === 1'h1) chk({hdr, rtl, serr, mnum}, exp_done.size() ? exp_done.pop_front() : 9'hx);
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short.
  initial begin
    #(40 * 20000);
    num_errors++;
    tally_and_finish();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h86dc3df3));
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    apb(1'h0, bmfd_pkg::OFS_CTRL, 32'h0, 32'h1, 1'h0);
    apb(1'h0, bmfd_pkg::OFS_MASK, 32'h0, 32'h0, 1'h0);
    apb(1'h0, 8'h20, 32'h0, 32'h0, 1'h1);
    apb(1'h1, 8'h20, 32'h1, 32'h0, 1'h1);
    apb(1'h1, bmfd_pkg::OFS_CTRL, 32'h0, 32'h0, 1'h0);
    chk(wready, 1'h0);
    apb(1'h1, bmfd_pkg::OFS_CTRL, 32'h1, 32'h0, 1'h0);
    msg('{5}, 6'h07, 4'h2, 1'h1, 1'h1, 1'h0, 1'h0);
    chk(irq, 1'h0);
    apb(1'h1, bmfd_pkg::OFS_MASK, 32'h1f, 32'h0, 1'h0);
    chk(irq, 1'h1);
    msg('{11}, 6'h07, 4'h1, 1'h1, 1'h0, 1'h1, 1'h0);
    apb(1'h0, bmfd_pkg::OFS_STAT, 32'h0, 32'h1b, 1'h0);
    apb(1'h0, bmfd_pkg::OFS_STAT, 32'h0, 32'h0, 1'h0);
    chk(irq, 1'h0);
    chk(serr, 1'h1);
    msg('{10, 21}, 6'h2a, 4'h3, 1'h0, 1'h0, 1'h0, 1'h1);
    chk(irq, 1'h1);
    apb(1'h0, bmfd_pkg::OFS_STAT, 32'h0, 32'h1, 1'h0);
    msg('{3, 7, 2, 4, 6}, 6'h15, 4'h0, 1'h1, 1'h1, 1'h0, 1'h0);
    apb(1'h0, bmfd_pkg::OFS_SIG, 32'h0, {8'h0, ~last_sig, last_sig, last_sig}, 1'h0);
    tally_and_finish();
  end
endmodule : bmfd_decoder_tb
